// File: dv/pcfg_ext_clk.sv
// External clock source that shares the clock pin with the device under test.
`timescale 1ns/1ps
module pcfg_ext_clk #(
  parameter int HALF = 24
) (
  input  wire logic clk_i,
  input  wire logic en_i,
  input  wire logic dev_o_i,
  input  wire logic dev_oe_i,
  output logic      pin_o
);
  logic [7:0] cnt_q;
  logic       lvl_q;

  always_ff @(posedge clk_i) begin
    if (!en_i) begin
      cnt_q <= 8'h00;
      lvl_q <= 1'b0;
    end else if (cnt_q == 8'(HALF - 1)) begin
      cnt_q <= 8'h00;
      lvl_q <= !lvl_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // The device owns the wire while it drives; a released wire carries the external clock while enabled, otherwise it is low.
  assign pin_o = dev_oe_i ? dev_o_i : (en_i & lvl_q);
endmodule

// File: dv/pcfg_top_tb.sv
// Self-checking bench for the clock and modulation configuration block.
`timescale 1ns/1ps
module pcfg_top_tb;
  logic                clk_i;
  logic                rst_i;
  logic                cyc;
  logic                we;
  logic [3:0]          adr;
  logic [31:0]         wdat;
  logic [31:0]         rdat;
  logic                ack;
  logic                ss_gnd;
  logic                fs_gnd;
  logic                as_gnd;
  logic [2:0]          mres;
  logic                ext_en;
  logic                pin;
  logic                clk_o;
  logic                clk_oe;
  pcfg_pkg::pcfg_pwm_t pwm;
  logic [31:0]         r;
  logic [7:0]          rnd;
  int                  bad_count;
  int                  num_checks;
  int                  d0;
  int                  dv;
  int                  lo;
  int                  hi;
  int                  n;

  pcfg_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .spread_spectrum_pin_grounded_i(ss_gnd),
    .frequency_set_pin_grounded_i(fs_gnd), .address_strap_pin_grounded_i(as_gnd), .mode_resistor_i(mres),
    .shared_clock_pin_i(pin), .shared_clock_pin_o(clk_o), .shared_clock_pin_oe_o(clk_oe), .pwm_o(pwm));
  pcfg_ext_clk u_ext (.clk_i(clk_i), .en_i(ext_en), .dev_o_i(clk_o), .dev_oe_i(clk_oe), .pin_o(pin));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = !clk_i;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Pin-mode decode of the mode resistor code into {in_phase, shift_half, parallel}.
  function automatic logic [2:0] dec(input logic [2:0] c);
    case (c)
      3'h1, 3'h5: dec = 3'b100;
      3'h2:       dec = 3'b010;
      3'h3:       dec = 3'b110;
      default:    dec = 3'b000;
    endcase
  endfunction

  function automatic int kof(input int s);
    case (s)
      1: kof = 3;
      2: kof = 4;
      3: kof = 6;
      4: kof = 8;
      5: kof = 9;
      default: kof = 0;
    endcase
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    r = rdat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic stat(input int w);
    repeat (w) @(posedge clk_i);
    bus(1'b0, 4'h8, 32'h0);
  endtask

  task automatic count_eq(input logic ph);
    n = 0;
    repeat (200) begin
      @(posedge clk_i);
      if (ph ? (pwm.ch1_n === pwm.ch1_p || pwm.ch2_n === pwm.ch2_p)
             : (pwm.ch2_p !== pwm.ch1_p || pwm.ch2_n !== pwm.ch1_n)) n++;
    end
  endtask

  // Cycles from a rising external clock edge to the next rising channel 1 drive, modulo the clock period.
  task automatic meas(output int d);
    logic p;
    p = 1'b1;
    @(posedge pin);
    for (d = 0; d < 100; d++) begin
      @(posedge clk_i);
      if (pwm.ch1_p === 1'b1 && !p) break;
      p = pwm.ch1_p;
    end
    d = d % 48;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #(60_000 * 40);
    bad_count++;
    end_of_test();
  end

  initial begin
    {cyc, we, adr, wdat, ss_gnd, fs_gnd, as_gnd, ext_en} = '0;
    mres = 3'h3;
    rst_i = 1'b1;
    bad_count = 0;
    num_checks = 0;
    rnd = 8'h5f;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b1, 4'hc, 32'hffffffff);
    bus(1'b0, 4'hc, 32'h0);
    chk(r, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    chk(r, 32'h0);
    ///////////////////////////////////////////////////////////////////////////
    for (int i = 0; i < 4; i++) begin
      ss_gnd <= i[0];
      fs_gnd <= i[1];
      ext_en <= i[1];
      stat(8);
      chk(32'(r[5:3]), {29'h0, 1'b1, i[1], !i[0]});
      chk(32'(clk_oe), 32'(!i[1]));
    end
    ///////////////////////////////////////////////////////////////////////////
    {fs_gnd, ext_en, ss_gnd, as_gnd} <= 4'b0011;
    for (int c = 0; c < 6; c++) begin
      mres <= 3'(c);
      bus(1'b1, 4'h0, 32'h0);
      bus(1'b1, 4'h0, 32'h1);
      stat(4);
      chk({r[10:8], r[5:0]}, {23'h0, 3'(c), 3'b000, dec(3'(c))});
    end
    mres <= 3'h2;
    bus(1'b1, 4'h0, 32'h7);
    stat(300);
    chk({r[27:16], 1'b0, r[10:8]}, {20'h0, 12'd80, 4'h5});
    ///////////////////////////////////////////////////////////////////////////
    as_gnd <= 1'b0;
    mres <= 3'h3;
    // Let the straps pass the synchroniser before the latch command.
    repeat (4) @(posedge clk_i);
    bus(1'b1, 4'h0, 32'h80);
    stat(4);
    chk({r[10:8], r[5], r[0]}, 32'h0f);
    mres <= 3'h0;
    bus(1'b1, 4'h0, 32'h08);
    bus(1'b1, 4'h0, 32'h09);
    stat(4);
    chk({r[10:8], r[5], r[2], r[0]}, 32'h06);
    for (int h = 0; h < 3; h++) begin
      lo = (h == 0) ? 80 : (h == 1) ? 88 : 72;
      bus(1'b1, 4'h0, 32'(2 * h + 1 + (h == 2 ? 2 : 0)));
      stat(300);
      chk(32'(r[27:16]), 32'(lo));
      n = 0;
      repeat (2 * lo) begin
        @(posedge clk_i);
        n += int'(clk_o);
      end
      chk(32'(n), 32'(lo));
    end
    ///////////////////////////////////////////////////////////////////////////
    ss_gnd <= 1'b0;
    bus(1'b1, 4'h0, 32'h1);
    lo = 999;
    hi = 0;
    for (int i = 0; i < 60; i++) begin
      stat(40);
      lo = (int'(r[27:16]) < lo) ? int'(r[27:16]) : lo;
      hi = (int'(r[27:16]) > hi) ? int'(r[27:16]) : hi;
    end
    chk(32'(lo), 32'd76);
    chk(32'(hi), 32'd84);
    ///////////////////////////////////////////////////////////////////////////
    ss_gnd <= 1'b1;
    rnd = lfsr(rnd);
    rnd = 8'h10 + 8'(rnd % 8'he0);
    bus(1'b1, 4'h4, {16'h0, ~rnd, rnd});
    count_eq(1'b1);
    chk(32'(n), 32'h0);
    bus(1'b1, 4'h0, 32'h09);
    count_eq(1'b1);
    chk(32'(n > 0), 32'h1);
    mres <= 3'h3;
    bus(1'b1, 4'h0, 32'h80);
    bus(1'b1, 4'h0, 32'h01);
    count_eq(1'b0);
    chk(32'(n), 32'h0);
    ///////////////////////////////////////////////////////////////////////////
    {fs_gnd, ext_en, ss_gnd} <= 3'b110;
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, 4'h0, {25'h0, 3'(s), 4'h1});
      repeat (300) @(posedge clk_i);
      meas(dv);
      if (s == 0) d0 = dv;
      else chk(32'((dv - d0 + 48) % 48), 32'(4 * kof(s)));
    end
    ss_gnd <= 1'b1;
    bus(1'b1, 4'h0, 32'h01);
    repeat (300) @(posedge clk_i);
    meas(d0);
    bus(1'b1, 4'h0, 32'h31);
    repeat (300) @(posedge clk_i);
    meas(dv);
    chk(32'(dv), 32'(d0));
    end_of_test();
  end
endmodule

// File: hw/pcfg_cfg.svh
// Constants for the PWM clock and modulation configuration block.
`ifndef PCFG_CFG_SVH
`define PCFG_CFG_SVH
`define PCFG_ADR_CTRL    4'h0
`define PCFG_ADR_DUTY    4'h4
`define PCFG_ADR_STAT    4'h8
`define PCFG_CTRL_RST    8'h00
`define PCFG_DUTY_RST    16'h8080
`define PCFG_LATCH_BIT   7
`define PCFG_NOM_PERIOD  80
`define PCFG_SS_DIV      20
`define PCFG_HOP_NUM     10
`define PCFG_HOP_LO_DEN  9
`define PCFG_HOP_HI_DEN  11
`define PCFG_MOD_SHORT   3'h0
`define PCFG_MOD_4K7     3'h1
`define PCFG_MOD_13K     3'h2
`define PCFG_MOD_33K     3'h3
`define PCFG_MOD_100K    3'h4
`define PCFG_MOD_OPEN    3'h5
`define PCFG_PAR_MIN     3'h3
`define PCFG_PSEL_QUART  3'h1
`define PCFG_PSEL_THIRD  3'h2
`define PCFG_PSEL_HALF   3'h3
`define PCFG_PSEL_2THIRD 3'h4
`define PCFG_PSEL_3QUART 3'h5
`define PCFG_PH_DEN      12
`define PCFG_PH_NONE     4'h0
`define PCFG_PH_QUART    4'h3
`define PCFG_PH_THIRD    4'h4
`define PCFG_PH_HALF     4'h6
`define PCFG_PH_2THIRD   4'h8
`define PCFG_PH_3QUART   4'h9
`define PCFG_DUTY_SHIFT  8
`define PCFG_STAT_PER_LSB 16
`endif

// File: hw/pcfg_pkg.sv
// Types shared by the PWM clock and modulation configuration block.
package pcfg_pkg;
  typedef struct packed {
    logic       latch_cmd;
    logic [2:0] phase_sel;
    logic       in_phase;
    logic       hop_dir;
    logic       hop_en;
    logic       run;
  } pcfg_ctrl_t;

  typedef struct packed {
    logic bus_mode;
    logic slave;
    logic ss_pll_on;
    logic in_phase;
    logic shift_half;
    logic parallel;
  } pcfg_mode_t;

  typedef struct packed {
    logic ch2_n;
    logic ch2_p;
    logic ch1_n;
    logic ch1_p;
  } pcfg_pwm_t;
endpackage

// File: hw/pcfg_sync.sv
// Two-flop synchroniser for strap and clock pins.
`timescale 1ns/1ps
module pcfg_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

// File: hw/pcfg_top.sv
// Switching clock and modulation configuration with a Wishbone register port.
// What this block does
// - Spread spectrum off when its pin grounded
// - Spread sweep is triangular within plus/minus five percent
// - Hop enable selects 0.9 or 1.1 nominal
// - Slave without PLL restarts on external edge
// - Decode four oscillator modes from the straps
// - Pin mode decodes six mode resistor codes to four settings
// - Bus mode uses resistor only for parallel
// - Latch command captures mode resistor decode in bus mode only
// - Otherwise capture strap when switching starts
// - Opposite phase drives bridge halves in antiphase
// - In phase mode inverts one half input
// - Phase offset only as slave with PLL
// - Bus selects one of five phase offsets
// - Parallel mode drives both stages as one
// - Parallel mode uses channel one settings only
// - Grounded address strap selects pin mode
// - Grounded frequency pin makes device clock slave
`timescale 1ns/1ps
`include "pcfg_cfg.svh"
module pcfg_top #(
  parameter int PW         = 12,
  parameter int NOM_PERIOD = `PCFG_NOM_PERIOD
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [3:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                spread_spectrum_pin_grounded_i,
  input  wire logic                frequency_set_pin_grounded_i,
  input  wire logic                address_strap_pin_grounded_i,
  input  wire logic [2:0]          mode_resistor_i,
  input  wire logic                shared_clock_pin_i,
  output logic                     shared_clock_pin_o,
  output logic                     shared_clock_pin_oe_o,
  output pcfg_pkg::pcfg_pwm_t      pwm_o
);
  localparam logic [PW-1:0] NOM  = PW'(NOM_PERIOD);
  localparam logic [PW-1:0] SPAN = PW'(NOM_PERIOD / `PCFG_SS_DIV);
  localparam logic [PW-1:0] HLO  = PW'(NOM_PERIOD * `PCFG_HOP_NUM / `PCFG_HOP_LO_DEN);
  localparam logic [PW-1:0] HHI  = PW'(NOM_PERIOD * `PCFG_HOP_NUM / `PCFG_HOP_HI_DEN);
  localparam logic [PW+3:0] PDEN = (PW+4)'(`PCFG_PH_DEN);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and strap decode.
  logic [6:0] pins_s;
  logic       ss_gnd;
  logic       fset_gnd;
  logic       ads_gnd;
  logic [2:0] mod_code;
  logic       ext_clk;
  logic       ext_clk_q;
  logic       ext_rise;

  pcfg_sync #(.W(7)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({spread_spectrum_pin_grounded_i, frequency_set_pin_grounded_i,
             address_strap_pin_grounded_i, mode_resistor_i, shared_clock_pin_i}),
    .q_o   (pins_s)
  );

  assign {ss_gnd, fset_gnd, ads_gnd, mod_code, ext_clk} = pins_s;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_clk_q <= 1'b0;
    end else begin
      ext_clk_q <= ext_clk;
    end
  end
  assign ext_rise = ext_clk & ~ext_clk_q;
  pcfg_pkg::pcfg_ctrl_t ctrl_q;
  logic [15:0]          duty_q;
  logic [2:0]           mod_lat_q;
  pcfg_pkg::pcfg_mode_t mode;
  logic                 hop_act;
  logic [3:0]           ph_k;
  // Phase select field to twelfths of a period; unknown codes give none.
  function automatic logic [3:0] psel_k(input logic [2:0] sel);
    unique case (sel)
      `PCFG_PSEL_QUART:  psel_k = `PCFG_PH_QUART;
      `PCFG_PSEL_THIRD:  psel_k = `PCFG_PH_THIRD;
      `PCFG_PSEL_HALF:   psel_k = `PCFG_PH_HALF;
      `PCFG_PSEL_2THIRD: psel_k = `PCFG_PH_2THIRD;
      `PCFG_PSEL_3QUART: psel_k = `PCFG_PH_3QUART;
      default:           psel_k = `PCFG_PH_NONE;
    endcase
  endfunction
  always_comb begin
    mode.bus_mode   = ~ads_gnd;
    mode.slave      = fset_gnd;
    mode.ss_pll_on  = ~ss_gnd;
    mode.in_phase   = mode.bus_mode ? ctrl_q.in_phase : mod_lat_q[0];
    mode.shift_half = ~mode.bus_mode &&
                      (mod_lat_q == `PCFG_MOD_13K || mod_lat_q == `PCFG_MOD_33K);
    mode.parallel   = mode.bus_mode && (mod_lat_q >= `PCFG_PAR_MIN);
    hop_act         = mode.bus_mode && !mode.slave && ctrl_q.hop_en;
    if (!(mode.slave && mode.ss_pll_on)) begin
      ph_k = `PCFG_PH_NONE;
    end else if (mode.bus_mode) begin
      ph_k = psel_k(ctrl_q.phase_sel);
    end else begin
      ph_k = mode.shift_half ? `PCFG_PH_HALF : `PCFG_PH_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone classic slave.
  logic wb_req;
  logic latch_wr;
  logic run_q;

  assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign latch_wr = wb_req && wb_we_i && wb_adr_i == `PCFG_ADR_CTRL && wb_sel_i[0] &&
                    wb_dat_i[`PCFG_LATCH_BIT] && mode.bus_mode;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `PCFG_CTRL_RST;
      duty_q <= `PCFG_DUTY_RST;
    end else if (wb_req && wb_we_i) begin
      if (wb_adr_i == `PCFG_ADR_CTRL && wb_sel_i[0]) begin
        ctrl_q <= wb_dat_i[7:0];
      end
      if (wb_adr_i == `PCFG_ADR_DUTY && wb_sel_i[0]) begin
        duty_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_adr_i == `PCFG_ADR_DUTY && wb_sel_i[1]) begin
        duty_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end
  logic [PW-1:0] period_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `PCFG_ADR_CTRL: wb_dat_o <= {24'h0, ctrl_q};
        `PCFG_ADR_DUTY: wb_dat_o <= {16'h0, duty_q};
        `PCFG_ADR_STAT: wb_dat_o <= {(16-PW)'(0), period_q, 5'h0, mod_lat_q,
                                     2'h0, mode};
        default:        wb_dat_o <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode resistor capture.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
    end else begin
      run_q <= ctrl_q.run;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_lat_q <= `PCFG_MOD_SHORT;
    end else if (latch_wr) begin
      mod_lat_q <= mod_code;
    end else if (ctrl_q.run && !run_q && !(mode.bus_mode && ctrl_q.latch_cmd)) begin
      mod_lat_q <= mod_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carrier period: master sweep or hop, slave measurement.
  logic [PW-1:0] ramp_q;
  logic [PW-1:0] sweep_q;
  logic          sweep_up_q;
  logic [PW-1:0] meas_cnt_q;
  logic [PW-1:0] meas_q;
  logic          wrap;
  assign wrap = ramp_q >= period_q - PW'(1);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sweep_q    <= SPAN;
      sweep_up_q <= 1'b1;
    end else if (wrap) begin
      if (sweep_up_q) begin
        sweep_q    <= sweep_q + PW'(1);
        sweep_up_q <= sweep_q + PW'(1) < SPAN + SPAN;
      end else begin
        sweep_q    <= sweep_q - PW'(1);
        sweep_up_q <= sweep_q - PW'(1) == '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meas_cnt_q <= '0;
      meas_q     <= NOM;
    end else if (ext_rise) begin
      meas_cnt_q <= '0;
      meas_q     <= meas_cnt_q + PW'(1);
    end else if (meas_cnt_q != '1) begin
      meas_cnt_q <= meas_cnt_q + PW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_q <= NOM;
    end else if (mode.slave) begin
      period_q <= meas_q;
    end else if (hop_act) begin
      period_q <= ctrl_q.hop_dir ? HHI : HLO;
    end else if (mode.ss_pll_on) begin
      period_q <= NOM - SPAN + sweep_q;
    end else begin
      period_q <= NOM;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carrier ramp with phase staggered restart in slave mode with PLL.
  logic [PW+3:0] ofs_prod;
  logic [PW-1:0] offset_q;
  logic [PW-1:0] dly_q;
  logic          dly_act_q;
  logic          restart;
  assign ofs_prod = {4'h0, meas_q} * {{PW{1'b0}}, ph_k};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      offset_q <= '0;
    end else begin
      offset_q <= PW'(ofs_prod / PDEN);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_q     <= '0;
      dly_act_q <= 1'b0;
    end else if (mode.slave && mode.ss_pll_on && ext_rise) begin
      dly_q     <= offset_q;
      dly_act_q <= 1'b1;
    end else if (dly_act_q) begin
      dly_q     <= dly_q - PW'(1);
      dly_act_q <= dly_q != '0;
    end
  end

  always_comb begin
    if (!mode.slave) begin
      restart = wrap;
    end else if (!mode.ss_pll_on) begin
      restart = ext_rise;
    end else begin
      restart = (dly_act_q && dly_q == '0) || wrap;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ramp_q <= '0;
    end else if (restart) begin
      ramp_q <= '0;
    end else begin
      ramp_q <= ramp_q + PW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock pin drive and bridge outputs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shared_clock_pin_o    <= 1'b0;
      shared_clock_pin_oe_o <= 1'b0;
    end else begin
      shared_clock_pin_o    <= !mode.slave && ramp_q < (period_q >> 1);
      shared_clock_pin_oe_o <= !mode.slave;
    end
  end

  logic [7:0]    duty2;
  logic [PW+7:0] th1_w;
  logic [PW+7:0] th2_w;
  logic [PW-1:0] th1;
  logic [PW-1:0] th2;
  assign duty2 = mode.parallel ? duty_q[7:0] : duty_q[15:8];
  assign th1_w = {8'h0, period_q} * {{PW{1'b0}}, duty_q[7:0]};
  assign th2_w = {8'h0, period_q} * {{PW{1'b0}}, duty2};
  assign th1   = th1_w[PW+7:`PCFG_DUTY_SHIFT];
  assign th2   = th2_w[PW+7:`PCFG_DUTY_SHIFT];
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_q.run) begin
      pwm_o <= '0;
    end else begin
      pwm_o.ch1_p <= ramp_q < th1;
      pwm_o.ch2_p <= ramp_q < th2;
      if (mode.in_phase) begin
        pwm_o.ch1_n <= ramp_q < period_q - th1;
        pwm_o.ch2_n <= ramp_q < period_q - th2;
      end else begin
        pwm_o.ch1_n <= !(ramp_q < th1);
        pwm_o.ch2_n <= !(ramp_q < th2);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_ss_off;
    !mode.slave && !mode.ss_pll_on && !hop_act ##1 !mode.slave && !mode.ss_pll_on
      && !hop_act |-> period_q == NOM;
  endproperty
  a_ss_off: assert property (p_ss_off) else $error("period not nominal");
  property p_ss_band;
    !mode.slave && mode.ss_pll_on && !hop_act ##1 !mode.slave && mode.ss_pll_on && !hop_act
      |-> period_q >= NOM - SPAN && period_q <= NOM + SPAN;
  endproperty
  a_ss_band: assert property (p_ss_band) else $error("period out of band");
  property p_hop;
    hop_act && !ctrl_q.hop_dir ##1 hop_act && !ctrl_q.hop_dir |-> period_q == HLO;
  endproperty
  a_hop: assert property (p_hop) else $error("hop low period wrong");
  property p_slave_direct;
    mode.slave && !mode.ss_pll_on && ext_rise |=> ramp_q == '0;
  endproperty
  a_slave_direct: assert property (p_slave_direct) else $error("no restart on edge");
  property p_latch;
    latch_wr |=> mod_lat_q == $past(mod_code);
  endproperty
  a_latch: assert property (p_latch) else $error("strap not captured");
  property p_antiphase;
    ctrl_q.run && $past(ctrl_q.run) && !$past(mode.in_phase) && !$past(rst_i)
      |-> pwm_o.ch1_n == !pwm_o.ch1_p;
  endproperty
  a_antiphase: assert property (p_antiphase) else $error("halves not antiphase");
  property p_no_offset;
    !(mode.slave && mode.ss_pll_on) ##1 !(mode.slave && mode.ss_pll_on) |-> offset_q == '0;
  endproperty
  a_no_offset: assert property (p_no_offset) else $error("offset outside slave pll");
  property p_parallel;
    mode.parallel && $past(mode.parallel) |-> pwm_o.ch2_p == pwm_o.ch1_p;
  endproperty
  a_parallel: assert property (p_parallel) else $error("channels differ in parallel");
  property p_slave_in;
    mode.slave ##1 mode.slave |-> !shared_clock_pin_oe_o;
  endproperty
  a_slave_in: assert property (p_slave_in) else $error("slave drives clock pin");
endmodule
